/* File: guard_cfg.svh */
/*
 * constants for the safety output supervisor: timing, register map, fields.
 * assumes a 50 MHz system clock and a 32-bit apb slave.
 */
`ifndef GUARD_CFG_SVH
`define GUARD_CFG_SVH
// ****************************************
// timing
// ****************************************
`define CLK_HZ 50000000
`define PRESS_MIN_MS 100
`define PRESS_MAX_MS 4000
`define FB_WIN_MS 500
`define AUTO_RST_MS 10000
// ****************************************
// register byte offsets
// ****************************************
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004
`define OFS_IRQ_ST 12'h008
`define OFS_IRQ_MASK 12'h00C
// ****************************************
// interrupt bit positions
// ****************************************
`define IRQ_FB_A 0
`define IRQ_FB_B 1
`define IRQ_FIELD 2
`define IRQ_ON 3
`define IRQ_W 4
// ****************************************
// display codes
// ****************************************
`define CODE_NONE 2'h0
`define CODE_FB_A 2'h1
`define CODE_FB_B 2'h2
`endif

/* File: guard_pkg.sv */
/*
 * types for the safety output supervisor.
 * assumes guard_cfg.svh is on the include path.
 */
`include "guard_cfg.svh"
package guard_pkg;
    // supervisor states, one-hot
    typedef enum logic [4:0] {
        ST_LOCKED = 5'h01,
        ST_FB_CHK = 5'h02,
        ST_ON_WAIT = 5'h04,
        ST_ON = 5'h08,
        ST_FAULT = 5'h10
    } sup_state_t;
    // apb request from master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    // apb answer to master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage

/* File: safety_restart_and_contactor_monitor.sv */
/*
 * safety output supervisor: restart interlock, dynamic contactor feedback
 * check, channel and range selection, apb registers and interrupt.
 * assumes inputs synchronous to CLK_SYS and RST asserted at power-up.
 */
// Local design decisions: the APB slave port and the register addresses.
// Summary of operation
// [R1] outputs stay off after interruption until reset
// [R2] power return waits locked for operator reset
// [R3] interlock always active, no enable needed
// [R4] press 0.1 s to 4 s switches outputs on
// [R5] too short or long press is ignored
// [R6] feedback monitor enabled by wiring only
// [R7] feedback closed required before every switch-on
// [R8] feedback must open within 500 ms after on
// [R9] feedback must close within 500 ms after off
// [R10] failed check drives outputs back off
// [R11] failure reported as code a or b
// [R12] feedback failure latches fault until power cycle
// [R13] factory wiring uses first channel
// [R14] reversed supply polarity selects second channel
// [R15] range pin halves emitted light power
// [R16] range control single channel, not safety
// [R17] yellow lit when locked and field free
// [R18] non-locking errors auto reset after 10 s
`timescale 1ns/1ns
module safety_restart_and_contactor_monitor
    import guard_pkg::*;
#(
    parameter int unsigned PRESS_MIN_CYC = `CLK_HZ / 1000 * `PRESS_MIN_MS,
    parameter int unsigned PRESS_MAX_CYC = `CLK_HZ / 1000 * `PRESS_MAX_MS,
    parameter int unsigned FB_WIN_CYC = `CLK_HZ / 1000 * `FB_WIN_MS,
    parameter int unsigned AUTO_RST_CYC = `CLK_HZ / 1000 * `AUTO_RST_MS
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // field, button, feedback, wiring
    input wire logic FIELD_FREE,
    input wire logic RESET_BUTTON,
    input wire logic FEEDBACK_CLOSED,
    input wire logic MONITOR_WIRED,
    input wire logic SUPPLY_REVERSED,
    input wire logic RANGE_PIN,
    input wire logic OTHER_ERROR,
    // outputs
    output logic SAFETY_OUT_A,
    output logic SAFETY_OUT_B,
    output logic YELLOW_LED,
    output logic SECOND_CHANNEL,
    output logic REDUCED_POWER,
    output logic [1:0] ERROR_CODE,
    output logic IRQ
);
    localparam int CW = 32;

    // whole state of the module
    typedef struct packed {
        sup_state_t st;
        logic [CW-1:0] tmr;         // feedback window timer
        logic [CW-1:0] press;       // button held time
        logic [CW-1:0] auto;        // auto reset timer
        logic btn_d;                // button previous level
        logic gen_err;              // non-locking error active
        logic [1:0] code;           // display error code
        logic [`IRQ_W-1:0] irq_st;  // sticky events
        logic [`IRQ_W-1:0] irq_mask;
        logic field_d;
        logic [31:0] rdata;
        logic force_off;            // software request to keep off
        logic acc_d;                // first access cycle seen, wait state
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    // saturating increment
    function automatic logic [CW-1:0] inc(input logic [CW-1:0] v);
        inc = (v == {CW{1'b1}}) ? v : v + 1'b1;
    endfunction

    // status word for reads
    function automatic logic [31:0] stat_word(input state_t s);
        stat_word = {24'h0, s.code, s.gen_err, s.st};
    endfunction

    // address decode of the register map, used only for the error flag; reads decode on their own
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `OFS_CTRL) || (a == `OFS_STAT) || (a == `OFS_IRQ_ST)
            || (a == `OFS_IRQ_MASK);
    endfunction

    logic apb_acc;
    logic apb_wr;
    logic apb_rd;
    logic apb_first;   // first access cycle, read data loads
    logic apb_rdy;     // ready edge, writes and clears act
    logic press_ok;
    logic btn_fall;
    logic [`IRQ_W-1:0] ev;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        cur_nxt = cur_r;
        ev = '0;
        // apb: one wait state so read data comes from a flip-flop at the ready edge
        apb_acc = PSEL && PENABLE;
        apb_first = apb_acc && !cur_r.acc_d;
        apb_rdy = apb_acc && cur_r.acc_d;
        apb_wr = apb_rdy && PWRITE;
        apb_rd = apb_first && !PWRITE;
        cur_nxt.acc_d = apb_first;
        cur_nxt.btn_d = RESET_BUTTON;
        cur_nxt.field_d = FIELD_FREE;
        btn_fall = cur_r.btn_d && !RESET_BUTTON;
        // press timing window
        press_ok = btn_fall && (cur_r.press >= CW'(PRESS_MIN_CYC))
            && (cur_r.press <= CW'(PRESS_MAX_CYC)); // [R4] [R5]
        if (RESET_BUTTON) begin
            cur_nxt.press = inc(cur_r.press);
        end else begin
            cur_nxt.press = '0;
        end
        if (cur_r.field_d && !FIELD_FREE) begin
            ev[`IRQ_FIELD] = 1'b1;
        end
        // non-locking error with auto reset
        if (OTHER_ERROR) begin
            cur_nxt.gen_err = 1'b1;
            cur_nxt.auto = '0;
        end else if (cur_r.gen_err) begin
            cur_nxt.auto = inc(cur_r.auto);
            if (cur_r.auto >= CW'(AUTO_RST_CYC - 1)) begin
                cur_nxt.gen_err = 1'b0; // [R18]
            end
        end
        cur_nxt.tmr = inc(cur_r.tmr);
        // supervisor
        case (cur_r.st)
            ST_LOCKED: begin
                // reset state after power-up too [R2] [R3]
                if (press_ok && FIELD_FREE && !cur_r.gen_err && !cur_r.force_off) begin
                    if (MONITOR_WIRED && !FEEDBACK_CLOSED) begin
                        cur_nxt.st = ST_LOCKED; // [R7] [R6]
                    end else begin
                        cur_nxt.st = MONITOR_WIRED ? ST_ON_WAIT : ST_ON;
                        cur_nxt.tmr = '0;
                        ev[`IRQ_ON] = 1'b1;
                    end
                end
            end
            ST_ON_WAIT: begin
                // outputs on, feedback must open
                if (!FIELD_FREE || cur_r.gen_err || cur_r.force_off) begin
                    cur_nxt.st = ST_FB_CHK; // [R1]
                    cur_nxt.tmr = '0;
                end else if (!FEEDBACK_CLOSED) begin
                    cur_nxt.st = ST_ON;
                end else if (cur_r.tmr >= CW'(FB_WIN_CYC - 1)) begin
                    cur_nxt.st = ST_FAULT; // [R8] [R10] [R12]
                    cur_nxt.code = `CODE_FB_A; // [R11]
                    ev[`IRQ_FB_A] = 1'b1;
                end
            end
            ST_ON: begin
                if (!FIELD_FREE || cur_r.gen_err || cur_r.force_off) begin
                    cur_nxt.st = MONITOR_WIRED ? ST_FB_CHK : ST_LOCKED; // [R1]
                    cur_nxt.tmr = '0;
                end
            end
            ST_FB_CHK: begin
                // outputs off, feedback must close
                if (FEEDBACK_CLOSED) begin
                    cur_nxt.st = ST_LOCKED;
                end else if (cur_r.tmr >= CW'(FB_WIN_CYC - 1)) begin
                    cur_nxt.st = ST_FAULT; // [R9] [R12]
                    cur_nxt.code = `CODE_FB_B; // [R11]
                    ev[`IRQ_FB_B] = 1'b1;
                end
            end
            ST_FAULT: begin
                cur_nxt.st = ST_FAULT; // [R12]
            end
            default: begin
                cur_nxt.st = ST_FAULT;
            end
        endcase
        // register writes
        if (apb_wr) begin
            if (PADDR == `OFS_CTRL) begin
                cur_nxt.force_off = PWDATA[0];
            end else if (PADDR == `OFS_IRQ_MASK) begin
                cur_nxt.irq_mask = PWDATA[`IRQ_W-1:0];
            end
        end
        // read data loads in the wait state and stands through the ready edge
        if (!apb_acc) begin
            cur_nxt.rdata = '0;
        end else if (apb_rd) begin
            if (PADDR == `OFS_CTRL) begin
                cur_nxt.rdata = {31'h0, cur_r.force_off};
            end else if (PADDR == `OFS_STAT) begin
                cur_nxt.rdata = stat_word(cur_r);
            end else if (PADDR == `OFS_IRQ_ST) begin
                cur_nxt.rdata = {28'h0, cur_r.irq_st};
            end else if (PADDR == `OFS_IRQ_MASK) begin
                cur_nxt.rdata = {28'h0, cur_r.irq_mask};
            end else begin
                cur_nxt.rdata = '0; // unmapped reads as zero
            end
        end
        // read-to-clear takes only the bits reported, a newer event is kept
        if (apb_rdy && !PWRITE && PADDR == `OFS_IRQ_ST) begin
            cur_nxt.irq_st = cur_r.irq_st & ~cur_r.rdata[`IRQ_W-1:0];
        end
        // set wins over the clear
        cur_nxt.irq_st = cur_nxt.irq_st | ev;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cur_r <= '{st: ST_LOCKED, code: `CODE_NONE, default: '0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic out_on;
    assign out_on = (cur_r.st == ST_ON) || (cur_r.st == ST_ON_WAIT);
    assign SAFETY_OUT_A = out_on;
    assign SAFETY_OUT_B = out_on;
    assign YELLOW_LED = (cur_r.st == ST_LOCKED) && cur_r.field_d; // [R17]
    assign SECOND_CHANNEL = SUPPLY_REVERSED; // [R13] [R14]
    assign REDUCED_POWER = RANGE_PIN; // [R15] [R16] plain pass, unmonitored
    assign ERROR_CODE = cur_r.code;
    assign IRQ = |(cur_r.irq_st & cur_r.irq_mask);
    assign PRDATA = cur_r.rdata;
    assign PREADY = apb_rdy;
    assign PSLVERR = apb_rdy && !mapped(PADDR);

    // ****************************************
    // assertions
    // ****************************************
    // window timer seen by the checks below
    logic [CW-1:0] fb_tmr_chk;
    assign fb_tmr_chk = cur_r.tmr;

    // ****************************************
    // restart interlock
    // ****************************************
    // a broken field drops the outputs on the next edge
    out_locked_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R1]
        !FIELD_FREE && out_on |=> !out_on)
        else $error("outputs stayed on with field broken");
    stay_off_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R1]
        !out_on && !FIELD_FREE |=> !out_on)
        else $error("outputs on while field broken");
    field_event_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R1]
        cur_r.field_d && !FIELD_FREE |=> cur_r.irq_st[`IRQ_FIELD])
        else $error("field break event lost");
    // no way on but an accepted press
    no_auto_on_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R2]
        !out_on && !press_ok |=> !out_on)
        else $error("outputs switched on without press");
    reset_locked_a: assert property (@(posedge CLK_SYS) // [R2] [R3]
        $fell(RST) |-> cur_r.st == ST_LOCKED && !out_on)
        else $error("not locked after reset");
    press_len_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R5]
        btn_fall && cur_r.press < CW'(PRESS_MIN_CYC) && cur_r.st == ST_LOCKED |=> !out_on)
        else $error("short press accepted");
    press_long_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R5]
        btn_fall && cur_r.press > CW'(PRESS_MAX_CYC) && cur_r.st == ST_LOCKED |=> !out_on)
        else $error("long press accepted");
    press_on_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R4]
        press_ok && cur_r.st == ST_LOCKED && FIELD_FREE && !cur_r.gen_err && !cur_r.force_off
        && (!MONITOR_WIRED || FEEDBACK_CLOSED) |=> out_on)
        else $error("valid press ignored");
    // non-locking errors hold off, clear later, never restart
    err_blocks_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R18]
        cur_r.gen_err && !out_on |=> !out_on)
        else $error("restart during error");
    auto_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R18]
        cur_r.gen_err && !OTHER_ERROR && cur_r.auto >= CW'(AUTO_RST_CYC - 1) |=> !cur_r.gen_err)
        else $error("error not cleared in time");

    // ****************************************
    // contactor feedback
    // ****************************************
    // switch-on only with a closed loop, when wired
    fb_closed_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R7]
        $rose(out_on) && $past(MONITOR_WIRED) |-> $past(FEEDBACK_CLOSED))
        else $error("switch-on with open feedback");
    unwired_on_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R6]
        $rose(out_on) && !$past(MONITOR_WIRED) |-> cur_r.st == ST_ON)
        else $error("unwired switch-on checked feedback");
    unwired_off_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R6]
        cur_r.st == ST_ON && !MONITOR_WIRED && !FIELD_FREE |=> cur_r.st == ST_LOCKED)
        else $error("unwired switch-off checked feedback");
    // open window after switch-on
    fb_open_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R8]
        cur_r.st == ST_ON_WAIT |-> fb_tmr_chk < CW'(FB_WIN_CYC))
        else $error("open window exceeded");
    open_seen_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R8]
        cur_r.st == ST_ON_WAIT && FIELD_FREE && !cur_r.gen_err && !cur_r.force_off
        && !FEEDBACK_CLOSED |=> cur_r.st == ST_ON)
        else $error("opened loop not accepted");
    // close window after switch-off
    fb_chk_entry_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R9]
        out_on && MONITOR_WIRED && !FIELD_FREE |=> cur_r.st == ST_FB_CHK)
        else $error("close check skipped");
    close_seen_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R9]
        cur_r.st == ST_FB_CHK && FEEDBACK_CLOSED |=> cur_r.st == ST_LOCKED)
        else $error("closed loop not accepted");
    fb_close_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R9]
        cur_r.st == ST_FB_CHK |-> fb_tmr_chk < CW'(FB_WIN_CYC))
        else $error("close window exceeded");
    // failures drop the outputs and latch a code
    fb_timeout_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R10]
        cur_r.st == ST_ON_WAIT && FIELD_FREE && !cur_r.gen_err && !cur_r.force_off
        && FEEDBACK_CLOSED && fb_tmr_chk >= CW'(FB_WIN_CYC - 1) |=> !out_on)
        else $error("outputs kept on after open timeout");
    fb_fault_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R10]
        cur_r.st == ST_FAULT |-> !SAFETY_OUT_A && !SAFETY_OUT_B)
        else $error("outputs on in fault");
    fault_code_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R11]
        cur_r.st == ST_FAULT |-> cur_r.code == `CODE_FB_A || cur_r.code == `CODE_FB_B)
        else $error("fault without code");
    fault_a_code_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R11]
        ev[`IRQ_FB_A] |=> ERROR_CODE == `CODE_FB_A)
        else $error("wrong code for open failure");
    fault_b_code_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R11]
        ev[`IRQ_FB_B] |=> ERROR_CODE == `CODE_FB_B)
        else $error("wrong code for close failure");
    fault_hold_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R12]
        cur_r.st == ST_FAULT |=> cur_r.st == ST_FAULT && cur_r.code != `CODE_NONE)
        else $error("fault left without power cycle");

    // ****************************************
    // outputs and indicator
    // ****************************************
    pair_equal_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R10]
        SAFETY_OUT_A == SAFETY_OUT_B)
        else $error("safety pair disagrees");
    yellow_led_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R17]
        YELLOW_LED |-> !out_on && $past(FIELD_FREE))
        else $error("yellow lit wrongly");
    lock_yellow_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [R17]
        cur_r.st == ST_LOCKED && cur_r.field_d |-> YELLOW_LED)
        else $error("yellow dark while unlockable");

    // ****************************************
    // covers
    // ****************************************
    // outputs switched on
    on_cov_c: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(out_on));
    // loop failed to open
    fault_a_cov_c: cover property (@(posedge CLK_SYS) disable iff (RST) ev[`IRQ_FB_A]);
    // loop failed to close
    fault_b_cov_c: cover property (@(posedge CLK_SYS) disable iff (RST) ev[`IRQ_FB_B]);
    // press of wrong length refused
    press_rej_c: cover property (@(posedge CLK_SYS) disable iff (RST)
        btn_fall && !press_ok && cur_r.st == ST_LOCKED);
    // non-locking error cleared itself
    auto_clr_c: cover property (@(posedge CLK_SYS) disable iff (RST) $fell(cur_r.gen_err));
endmodule // safety_restart_and_contactor_monitor

/* File: contactor_model.sv */
/* contactor pair with positive-guided feedback contact.
 * assumes the safety output drives both coils together. */
`timescale 1ns/1ns
module contactor_model #(
    parameter int unsigned DELAY = 5
) (
    // clock and coil
    input wire logic clk,
    input wire logic coil,
    // faults ordered by the bench
    input wire logic stuck_closed,
    input wire logic stuck_open,
    // feedback contact, high = closed
    output logic fb_closed
);
    int cnt; // cycles since coil changed
    logic coil_q; // coil seen last cycle
    initial begin
        cnt = 0;
        coil_q = 1'b0;
    end
    // ****************************************
    // feedback contact takes the inverse of coil after DELAY cycles
    // ****************************************
    always @(posedge clk) begin
        coil_q <= coil;
        cnt <= (coil != coil_q) ? 0 : cnt + 1;
    end
    // opens after on, closes after off, well inside the window
    assign fb_closed = stuck_open ? 1'b0 : stuck_closed ? 1'b1 :
        (cnt >= DELAY) ? !coil_q : coil_q;
endmodule // contactor_model

/* File: tb_safety_restart_and_contactor_monitor.sv */
/* bench for the safety output supervisor.
 * assumes small press and window counts, contactor_model on the feedback. */
`timescale 1ns/1ns
module tb_safety_restart_and_contactor_monitor;
    import guard_pkg::*;
    logic clk, rst, psel, penable, pwrite, button, field_free, stuck_c, stuck_o;
    logic sup_rev, range_pin, pready, pslverr, out_a, out_b, yellow, second_ch, red_pow, irq, fb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] err_code;
    logic er;
    logic mon_wired, oth_err;
    int mismatches, cmp_count;
    typedef struct {int hold; logic rev; logic rng; logic on;} row_t;
    row_t rows[4] = '{'{5, 0, 0, 0}, '{12, 1, 0, 1}, '{38, 0, 1, 1}, '{60, 1, 1, 0}};
    // ****************************************
    // clock, dut, contactors
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = !clk;
    end
    safety_restart_and_contactor_monitor #(.PRESS_MIN_CYC(10), .PRESS_MAX_CYC(40),
        .FB_WIN_CYC(20), .AUTO_RST_CYC(50)) dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .FIELD_FREE(field_free), .RESET_BUTTON(button),
        .FEEDBACK_CLOSED(fb), .MONITOR_WIRED(mon_wired), .SUPPLY_REVERSED(sup_rev),
        .RANGE_PIN(range_pin), .OTHER_ERROR(oth_err), .SAFETY_OUT_A(out_a), .SAFETY_OUT_B(out_b),
        .YELLOW_LED(yellow), .SECOND_CHANNEL(second_ch), .REDUCED_POWER(red_pow),
        .ERROR_CODE(err_code), .IRQ(irq));
    contactor_model cm (.clk(clk), .coil(out_a), .stuck_closed(stuck_c), .stuck_open(stuck_o),
        .fb_closed(fb));
    // ****************************************
    // tasks
    // ****************************************
    task automatic give_verdict();
        if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    // run limit: a hang counts as a mismatch and ends the run
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    // one apb transfer; waits for pready, takes read data at that edge
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 10; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 10) mismatches++;
        er = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // press the button for n cycles then release
    task automatic press(int n);
        button <= 1'b1;
        cyc(n);
        button <= 1'b0;
        cyc(3);
    endtask
    // break the field, let contactors drop, clear it again
    task automatic field_break();
        field_free <= 1'b0;
        cyc(3);
        chk("out_a", 0, out_a);
        cyc(12);
        field_free <= 1'b1;
        cyc(3);
        chk("out_a", 0, out_a);
        chk("yellow", 1, yellow);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, button, stuck_c, stuck_o} = '0;
        {sup_rev, range_pin, mismatches, cmp_count} = '0;
        field_free = 1'b1;
        mon_wired = 1'b1;
        oth_err = 1'b0;
        rst = 1'b1;
        cyc(20);
        rst <= 1'b0;
        cyc(1);
        chk("out_b", 0, out_b);
        apb(1'b0, 12'h004, 32'h0);
        chk("stat", 32'h1, rd);
        apb(1'b1, 12'h00C, 32'h8);
        foreach (rows[k]) begin
            sup_rev <= rows[k].rev;
            range_pin <= rows[k].rng;
            press(rows[k].hold);
            chk("out_a", rows[k].on, out_a);
            chk("out_b", rows[k].on, out_b);
            chk("second_ch", rows[k].rev, second_ch);
            chk("red_pow", rows[k].rng, red_pow);
            field_break();
        end
        chk("irq", 1, irq);
        apb(1'b0, 12'h008, 32'h0);
        chk("irq_st", 32'hC, rd);
        cyc(1);
        chk("irq", 0, irq);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 1, er);
        chk("unmapped", 0, rd);
        // contact welded: never opens after switch-on
        stuck_c <= 1'b1;
        press(12);
        chk("out_a", 1, out_a);
        cyc(25);
        chk("out_a", 0, out_a);
        chk("code", 1, err_code);
        apb(1'b0, 12'h004, 32'h0);
        chk("stat", 32'h50, rd);
        stuck_c <= 1'b0;
        cyc(10);
        press(12);
        chk("out_a", 0, out_a);
        // power cycle, then an open loop refuses switch-on
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        stuck_o <= 1'b1;
        cyc(2);
        chk("code", 0, err_code);
        press(12);
        chk("out_a", 0, out_a);
        // monitoring unwired: the open loop no longer matters
        mon_wired <= 1'b0;
        press(12);
        chk("out_a", 1, out_a);
        field_break();
        mon_wired <= 1'b1;
        stuck_o <= 1'b0;
        // non-locking error: press refused, clears alone, never restarts
        oth_err <= 1'b1;
        cyc(2);
        oth_err <= 1'b0;
        apb(1'b0, 12'h004, 32'h0);
        chk("stat", 32'h21, rd);
        press(12);
        chk("out_a", 0, out_a);
        cyc(60);
        chk("out_a", 0, out_a);
        press(12);
        chk("out_a", 1, out_a);
        // software hold-off drops the outputs and blocks a press
        apb(1'b1, 12'h000, 32'h1);
        cyc(2);
        chk("out_a", 0, out_a);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 1, rd);
        press(12);
        chk("out_a", 0, out_a);
        apb(1'b1, 12'h000, 32'h0);
        press(12);
        chk("out_a", 1, out_a);
        give_verdict();
    end
endmodule // tb_safety_restart_and_contactor_monitor
